// ---- rtl/isu_status.sv ----
// Upper status flags (bits 15..11) of the interrupt status register.
// Assumes all event inputs are single-cycle pulses on clk_i except the
// oscillator lock level, which comes from the analogue domain.
`timescale 1ns/1ps
`default_nettype none

module isu_status
   import isu_pkg::*;
(
   input  wire logic        clk_i,             // Core clock, 200 MHz.
   input  wire logic        nrst_i,            // Synchronous reset, active low.
   input  wire logic        use_strm_mode_i,   // Stream mode select.
   input  wire logic        unlock_irq_en_i,   // Unlock interrupt enable.
   input  wire logic        first_local_oscillator_unlocked_i, // Out of lock, async.
   input  wire logic        ram_addr_ovf_i,    // Recursive access ran past top.
   input  wire logic        ram_collide_i,     // RAM access during busy radio.
   input  wire logic        strm_tx_done_i,    // Stream transmit back in idle.
   input  wire logic        strm_rx_done_i,    // Stream receive back in idle.
   input  wire isu_dir_t    strm_dir_i,        // Direction of stream session.
   input  wire logic        rx_word_new_i,     // New receive word presented.
   input  wire logic        rx_word_read_i,    // Host read the receive word.
   input  wire logic        tx_word_done_i,    // Transmit word finished.
   input  wire logic        tx_word_wr_i,      // Host wrote next transmit word.
   input  wire logic        rd_req_valid_i,    // Host read of status register.
   output logic             rd_req_ready_o,    // Read request accepted.
   output logic             rd_data_valid_o,   // Read data available.
   input  wire logic        rd_data_ready_i,   // Host takes read data.
   output logic [15:0]      rd_data_o,         // Status word, upper field.
   output logic             irq_o,             // Interrupt request.
   output logic             abort_op_o         // Abort any active operation.
);

   // ==========================================================
   // Lock level synchroniser
   // ==========================================================
   // Three stages; the level changes once stages two and three agree.
   logic [2:0] lock_sync_reg;
   logic       unlocked_reg;

   // Shift the raw level in.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lock_sync_reg <= 3'h0;
      end else begin
         lock_sync_reg <= {lock_sync_reg[1:0], first_local_oscillator_unlocked_i};
      end
   end

   // Accept a new level only when the last two stages agree.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         unlocked_reg <= 1'h0;
      end else if (lock_sync_reg[1] == lock_sync_reg[2]) begin
         unlocked_reg <= lock_sync_reg[2];
      end
   end

   // ==========================================================
   // Word pending trackers
   // ==========================================================
   logic rx_pending_reg;   // Receive word waits for the host.
   logic tx_loaded_reg;    // Next transmit word has been written.
   logic rx_overrun;       // New word lands on an unread one.
   logic tx_underrun;      // Word finishes with no successor.

   assign rx_overrun  = (strm_dir_i == ISU_DIR_RX) && rx_word_new_i && rx_pending_reg
                        && !rx_word_read_i;
   assign tx_underrun = (strm_dir_i == ISU_DIR_TX) && tx_word_done_i && !tx_loaded_reg
                        && !tx_word_wr_i;

   // Track whether the presented receive word has been read.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rx_pending_reg <= 1'h0;
      end else if (rx_word_new_i) begin
         rx_pending_reg <= 1'h1;
      end else if (rx_word_read_i) begin
         rx_pending_reg <= 1'h0;
      end
   end

   // Track whether the host has supplied the next transmit word.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tx_loaded_reg <= 1'h0;
      end else if (tx_word_wr_i) begin
         tx_loaded_reg <= 1'h1;
      end else if (tx_word_done_i) begin
         tx_loaded_reg <= 1'h0;
      end
   end

   // ==========================================================
   // Sticky flags
   // ==========================================================
   logic unlock_flag_reg;   // Bit 15.
   logic mux14_reg;         // Bit 14.
   logic mux13_reg;         // Bit 13.
   logic word_err_reg;      // Bit 12.
   logic set14;
   logic set13;
   logic set12;
   logic rd_take;           // A status read is taken this cycle.

   assign set14 = use_strm_mode_i ? strm_tx_done_i : ram_addr_ovf_i;
   assign set13 = use_strm_mode_i ? strm_rx_done_i : ram_collide_i;
   assign set12 = use_strm_mode_i && (rx_overrun || tx_underrun);

   // Unlock flag follows the lock level, held until read.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         unlock_flag_reg <= 1'h0;
      end else if (unlocked_reg) begin
         unlock_flag_reg <= 1'h1;
      end else if (rd_take) begin
         unlock_flag_reg <= 1'h0;
      end
   end

   // A set in the clearing cycle wins.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mux14_reg    <= 1'h0;
         mux13_reg    <= 1'h0;
         word_err_reg <= 1'h0;
      end else begin
         mux14_reg    <= set14 | (mux14_reg & ~rd_take);
         mux13_reg    <= set13 | (mux13_reg & ~rd_take);
         word_err_reg <= set12 | (word_err_reg & ~rd_take);
      end
   end

   // Request while unlock flag stands and the unlock interrupt is enabled; abort while the flag stands.
   assign irq_o      = unlock_flag_reg & unlock_irq_en_i;
   assign abort_op_o = unlock_flag_reg;

   // ==========================================================
   // Two-entry read buffer
   // ==========================================================
   logic [15:0] buf_mem [BUF_DEPTH];   // Captured status words.
   logic        wr_ptr_reg;            // Next slot to fill.
   logic        rd_ptr_reg;            // Next slot to drain.
   logic [1:0]  count_reg;             // Words held.
   logic        rd_give;               // Host drains a word.
   logic [15:0] snap;                  // Status word being captured.

   assign rd_req_ready_o  = (count_reg != 2'h2);
   assign rd_take         = rd_req_valid_i && rd_req_ready_o;
   assign rd_data_valid_o = (count_reg != 2'h0);
   assign rd_give         = rd_data_valid_o && rd_data_ready_i;
   assign rd_data_o       = buf_mem[rd_ptr_reg];

   // Reserved bit and lower field read as zero.
   always_comb begin
      snap               = STATUS_RESET;
      snap[BIT_UNLOCK]   = unlock_flag_reg;
      snap[BIT_MUX14]    = mux14_reg;
      snap[BIT_MUX13]    = mux13_reg;
      snap[BIT_WORD_ERR] = word_err_reg;
   end

   // Store a snapshot on each accepted read.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         buf_mem[0] <= STATUS_RESET;
         buf_mem[1] <= STATUS_RESET;
      end else if (rd_take) begin
         buf_mem[wr_ptr_reg] <= snap;
      end
   end

   // Pointer and fill bookkeeping.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wr_ptr_reg <= 1'h0;
         rd_ptr_reg <= 1'h0;
         count_reg  <= 2'h0;
      end else begin
         if (rd_take) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (rd_give) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, rd_take} - {1'b0, rd_give};
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   property p_unlock_follows;
      @(posedge clk_i) disable iff (!nrst_i)
      unlocked_reg |=> unlock_flag_reg;
   endproperty
   a_unlock_follows: assert property (p_unlock_follows) else $error("unlock flag missed");

   property p_irq_abort;
      @(posedge clk_i) disable iff (!nrst_i)
      unlocked_reg |=> (abort_op_o && (irq_o == unlock_irq_en_i));
   endproperty
   a_irq_abort: assert property (p_irq_abort) else $error("unlock request missing");

   property p_ovf;
      @(posedge clk_i) disable iff (!nrst_i)
      (!use_strm_mode_i && ram_addr_ovf_i) |=> mux14_reg;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag missed");

   property p_txdone;
      @(posedge clk_i) disable iff (!nrst_i)
      (use_strm_mode_i && strm_tx_done_i) |=> mux14_reg;
   endproperty
   a_txdone: assert property (p_txdone) else $error("tx done flag missed");

   property p_coll;
      @(posedge clk_i) disable iff (!nrst_i)
      (!use_strm_mode_i && ram_collide_i) |=> mux13_reg;
   endproperty
   a_coll: assert property (p_coll) else $error("collision flag missed");

   property p_rxdone;
      @(posedge clk_i) disable iff (!nrst_i)
      (use_strm_mode_i && strm_rx_done_i) |=> mux13_reg;
   endproperty
   a_rxdone: assert property (p_rxdone) else $error("rx done flag missed");

   property p_rx_overrun;
      @(posedge clk_i) disable iff (!nrst_i)
      (use_strm_mode_i && rx_overrun) |=> word_err_reg;
   endproperty
   a_rx_overrun: assert property (p_rx_overrun) else $error("overrun missed");

   property p_tx_underrun;
      @(posedge clk_i) disable iff (!nrst_i)
      (use_strm_mode_i && tx_underrun) |=> word_err_reg;
   endproperty
   a_tx_underrun: assert property (p_tx_underrun) else $error("underrun missed");

   property p_read_clears;
      @(posedge clk_i) disable iff (!nrst_i)
      (rd_take && !set12) |=> !word_err_reg;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear");

   property p_set_wins;
      @(posedge clk_i) disable iff (!nrst_i)
      (rd_take && set14) |=> mux14_reg;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

   c_read: cover property (@(posedge clk_i) disable iff (!nrst_i) rd_take ##1 rd_give);
   c_full: cover property (@(posedge clk_i) disable iff (!nrst_i) count_reg == 2'h2);
   c_irq:  cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(irq_o));
   c_err:  cover property (@(posedge clk_i) disable iff (!nrst_i) set12);

endmodule : isu_status

`default_nettype wire

// ---- include/isu_pkg.sv ----
// Constants for the upper interrupt status flag logic.
// Assumes a single 200 MHz core clock and a synchronous active-low reset.
package isu_pkg;
   // ==========================================================
   // Register map
   // ==========================================================
   // Byte-free register index of the interrupt status register.
   localparam logic [7:0]  STATUS_OFFSET     = 8'h24;
   // Reset value of the upper status field.
   localparam logic [15:0] STATUS_RESET      = 16'h0000;
   // Field positions inside the status word.
   localparam int          BIT_UNLOCK        = 15;
   localparam int          BIT_MUX14         = 14;
   localparam int          BIT_MUX13         = 13;
   localparam int          BIT_WORD_ERR      = 12;
   localparam int          BIT_RESERVED      = 11;
   // Depth of the status word buffer towards the host.
   localparam int          BUF_DEPTH         = 2;
   // Direction of a stream session.
   typedef enum logic {ISU_DIR_RX, ISU_DIR_TX} isu_dir_t;
endpackage : isu_pkg

// ---- bench/isu_host.sv ----
// Host model: issues status reads and takes back the returned words.
// Assumes the status block's read handshake on the shared core clock.
`timescale 1ns/1ps
`default_nettype none
module isu_host
   import isu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        go_i,
   input  wire logic        stall_i,
   input  wire logic        req_ready_i,
   input  wire logic        data_valid_i,
   input  wire logic [15:0] data_i,
   output logic             req_valid_o,
   output logic             data_ready_o,
   output logic [15:0]      word_o,
   output logic [7:0]       got_o
);
   // ==========================================================
   // Read request
   // ==========================================================
   logic taken_reg;  // The request was accepted at the last edge.
   // The request is held from a falling edge until an edge accepts it.
   always @(negedge clk_i) begin
      if (!nrst_i || taken_reg) begin
         req_valid_o <= 1'b0;
      end else if (go_i) begin
         req_valid_o <= 1'b1;
      end
   end
   // Acceptance is seen at the rising edge.
   always_ff @(posedge clk_i) begin
      taken_reg <= nrst_i && req_valid_o && req_ready_i;
   end
   // ==========================================================
   // Returned words
   // ==========================================================
   // A stall holds off the drain so the buffer can fill.
   assign data_ready_o = !stall_i;
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         got_o <= 8'h00;
      end else if (data_valid_i && data_ready_o) begin
         word_o <= data_i;
         got_o  <= got_o + 8'h01;
      end
   end
endmodule : isu_host
`default_nettype wire

// ---- bench/isu_status_tb.sv ----
// Testbench for the upper status flags: events, reads and buffering.
// Assumes the host model isu_host on the far side of the read port.
`timescale 1ns/1ps
`default_nettype none
module isu_status_tb import isu_pkg::*;;
   logic        clk, nrst, mode, en, unl, go, stall;
   isu_dir_t    dir;
   logic [7:0]  ev;     // Event pulses, one bit for each event input.
   logic        req_v, req_r, dat_v, dat_r, irq, abt;
   logic [15:0] dat, word;
   logic [7:0]  got, seen;
   int          n_errors = 0;
   int          tests_run = 0;
   isu_status isu_status_i (.clk_i(clk), .nrst_i(nrst), .use_strm_mode_i(mode),
      .unlock_irq_en_i(en), .first_local_oscillator_unlocked_i(unl), .ram_addr_ovf_i(ev[0]),
      .ram_collide_i(ev[1]), .strm_tx_done_i(ev[2]), .strm_rx_done_i(ev[3]),
      .strm_dir_i(dir), .rx_word_new_i(ev[4]), .rx_word_read_i(ev[5]),
      .tx_word_done_i(ev[6]), .tx_word_wr_i(ev[7]), .rd_req_valid_i(req_v),
      .rd_req_ready_o(req_r), .rd_data_valid_o(dat_v), .rd_data_ready_i(dat_r),
      .rd_data_o(dat), .irq_o(irq), .abort_op_o(abt));
   isu_host isu_host_i (.clk_i(clk), .nrst_i(nrst), .go_i(go), .stall_i(stall),
      .req_ready_i(req_r), .data_valid_i(dat_v), .data_i(dat), .req_valid_o(req_v),
      .data_ready_o(dat_r), .word_o(word), .got_o(got));
   // ==========================================================
   // Shared tasks
   // ==========================================================
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic pulse(input logic [7:0] m);
      @(negedge clk);
      ev <= m;
      @(negedge clk);
      ev <= 8'h00;
   endtask : pulse
   task automatic issue();
      @(negedge clk);
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      repeat (3) @(negedge clk);
   endtask : issue
   task automatic collect(input string nm, input logic [15:0] e);
      int i;
      for (i = 0; i < 20 && got == seen; i++) @(negedge clk);
      chk("count", {8'h00, seen + 8'h01}, {8'h00, got});
      seen = seen + 8'h01;
      chk(nm, e, word);
   endtask : collect
   task automatic rd(input string nm, input logic [15:0] e);
      issue();
      collect(nm, e);
   endtask : rd
   task automatic drain(input string nm, input logic [15:0] e);
      @(negedge clk);
      stall <= 1'b0;
      @(negedge clk);
      stall <= 1'b1;
      collect(nm, e);
   endtask : drain
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_flags();
      mode <= 1'b0;
      pulse(8'h03);
      rd("packet flags", 16'h6000);
      rd("cleared", 16'h0000);
      mode <= 1'b1;
      pulse(8'h04);
      rd("tx done", 16'h4000);
      pulse(8'h08);
      rd("rx done", 16'h2000);
   endtask : t_flags
   task automatic t_word();
      dir <= ISU_DIR_RX;
      pulse(8'h10);
      pulse(8'h20);
      pulse(8'h10);
      rd("rx in order", 16'h0000);
      pulse(8'h10);
      rd("rx overrun", 16'h1000);
      dir <= ISU_DIR_TX;
      pulse(8'h80);
      pulse(8'h40);
      pulse(8'h80);
      pulse(8'h40);
      rd("tx in order", 16'h0000);
      pulse(8'h40);
      rd("tx underrun", 16'h1000);
   endtask : t_word
   task automatic t_unlock();
      unl <= 1'b1;
      repeat (8) @(negedge clk);
      chk("irq abort", 16'h0003, {14'h0000, irq, abt});
      rd("unlocked", 16'h8000);
      rd("still unlocked", 16'h8000);
      en <= 1'b0;
      @(negedge clk);
      chk("masked", 16'h0001, {14'h0000, irq, abt});
      unl <= 1'b0;
      repeat (8) @(negedge clk);
      en <= 1'b1;
      rd("relocked", 16'h8000);
      rd("locked", 16'h0000);
      chk("released", 16'h0000, {14'h0000, irq, abt});
   endtask : t_unlock
   task automatic t_race();
      mode <= 1'b0;
      @(negedge clk);
      go <= 1'b1;
      @(negedge clk);
      go <= 1'b0;
      ev <= 8'h01;
      @(negedge clk);
      ev <= 8'h00;
      collect("snapshot", 16'h0000);
      rd("kept", 16'h4000);
   endtask : t_race
   task automatic t_buffer();
      stall <= 1'b1;
      pulse(8'h01);
      issue();
      pulse(8'h02);
      issue();
      chk("full", 16'h0001, {14'h0000, req_r, dat_v});
      pulse(8'h01);
      issue();
      drain("first", 16'h4000);
      drain("second", 16'h2000);
      drain("refused kept", 16'h4000);
      stall <= 1'b0;
   endtask : t_buffer
   task automatic report_and_stop();
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // Clock, watchdog and main sequence
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // The run needs well under 1000 cycles; this cuts a hang short.
   initial begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      {nrst, mode, en, unl, go, stall} = 6'b001000;
      {ev, seen} = 16'h0000;
      dir = ISU_DIR_RX;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("reset outputs", 16'h0008, {12'h000, req_r, dat_v, irq, abt});
      nrst <= 1'b1;
      t_flags();
      t_word();
      t_unlock();
      t_race();
      t_buffer();
      report_and_stop();
   end
endmodule : isu_status_tb
`default_nettype wire
